// ### rtl/hsi2c_pkg.sv
// Constants and types shared by the host-side I2C slave link.
//Contract
//- Only selected host interface reaches buffer manager.
//- Seven-bit address, fixed prefix plus two bits.
//- Ten-bit addressing never matches.
//- Configuration changes wait while busy.
//- Half duplex standard, fast, high-speed modes.
//- High-speed enable acks address, sets pad mode.
//- Never stretch the clock.
//- Address-write ack needs select, match, buffer.
//- Data byte ack needs buffer, else discard.
//- Native mode ignores frame overflow.
//- Address-read ack needs select, match, frame.
//- Idle bytes read as all ones.
//- Device-id flag with request, three bytes.
//- Device-id disabled nacks both addresses.
//- Device-id only in standard or fast.
//- General call six raises reset until end.
//- System reset clears soft-reset enable.
//- Only soft-reset general call, not high-speed.
//- Separate 25 ns start and stop filters.
package hsi2c_pkg;
  localparam logic [2:0] SEL_NONE        = 3'h0;
  localparam logic [2:0] SEL_I2C         = 3'h1;
  localparam logic [2:0] SEL_UART        = 3'h3;
  localparam logic [2:0] SEL_SPI_USB     = 3'h4;
  localparam logic [6:0] GEN_CALL_ADDR   = 7'h00;
  localparam logic [6:0] DEVID_ADDR      = 7'h7c;
  localparam logic [3:0] TEN_BIT_PREFIX  = 4'hf;
  localparam logic [4:0] HS_CODE_PREFIX  = 5'h01;
  localparam logic [7:0] SOFT_RESET_CMD  = 8'h06;
  localparam logic [7:0] IDLE_BYTE       = 8'hff;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [1:0] DEVID_BYTES     = 2'h3;
  localparam int         DATA_W          = 8;
  localparam int         FIFO_DEPTH      = 16;
  localparam int         CLK_PERIOD_NS   = 50;
  localparam int         FILTER_NS       = 25;
  localparam int         FILTER_RAW      = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         FILTER_CYC      = (FILTER_RAW < 1) ? 1 : FILTER_RAW;
  localparam int         SM_KBPS         = 100;
  localparam int         FM_KBPS         = 400;
  localparam int         HS_KBPS         = 3400;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_RDATA, ST_RACK, ST_SKIP
  } hsi2c_state_t;
endpackage

// ### rtl/hsi2c_slave.sv
// Host-side I2C slave link with its receive FIFO toward the buffer manager.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module hsi2c_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ff];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module hsi2c_slave (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] host_if_select,
  input  wire logic [1:0] cfg_addr_lsb,
  input  wire logic       high_speed_enable,
  input  wire logic       soft_reset_enable,
  input  wire logic       device_id_enable,
  input  wire logic       sys_reset_seen,
  input  wire logic       native_mode,
  input  wire logic       rx_buf_avail,
  input  wire logic       rx_frame_ovf,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            busy,
  output logic            hs_pad_mode,
  output logic            soft_reset_out,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            rx_eof,
  output logic            rx_discard,
  input  wire logic       tx_frame_avail,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_req,
  output logic            device_id_req
);
  // Upper address bits; the value is arbitrary.
  localparam logic [4:0] ADDR_PREFIX = 5'h16;

  function automatic logic filt_next(input logic s2, input logic s3, input logic cur);
    filt_next = (s2 == s3) ? s3 : cur;
  endfunction

  logic [2:0]   scl_sync_ff;
  logic [2:0]   sda_sync_ff;
  logic         scl_ff;
  logic         sda_ff;
  logic         scl_rise;
  logic         scl_fall;
  logic         sda_fell;
  logic         sda_rose;
  logic         start_arm_ff;
  logic         stop_arm_ff;
  logic [3:0]   start_cnt_ff;
  logic [3:0]   stop_cnt_ff;
  logic         start_det;
  logic         stop_det;
  hsi2c_pkg::hsi2c_state_t state_ff;
  logic [6:0]   shift_ff;
  logic [7:0]   tx_shift_ff;
  logic [2:0]   bitcnt_ff;
  logic         sda_drv_ff;
  logic         ack_ok_ff;
  logic         ack_drv_ff;
  logic         read_ff;
  logic         mack_ff;
  logic         hs_active_ff;
  logic         gc_pend_ff;
  logic         devid_pend_ff;
  logic         devid_armed_ff;
  logic         devid_act_ff;
  logic [1:0]   devid_cnt_ff;
  logic         wframe_ff;
  logic [1:0]   addr_lsb_ff;
  logic         hs_en_ff;
  logic         srst_en_ff;
  logic         srst_cfg_prev_ff;
  logic         devid_en_ff;
  logic         srst_out_ff;
  logic         eof_ff;
  logic         discard_ff;
  logic [7:0]   byte_in;
  logic         sel_i2c;
  logic         addr_match;
  logic         write_ok;
  logic         byte_done;
  logic         fifo_push;
  logic         fifo_in_ready;
  logic         load_tx;
  logic         take_tx;
  logic         nxt_ack;

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling: three stages, a level counts once stages two and three agree.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_ff      <= 1'b1;
      sda_ff      <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
      scl_ff      <= filt_next(scl_sync_ff[1], scl_sync_ff[2], scl_ff);
      sda_ff      <= filt_next(sda_sync_ff[1], sda_sync_ff[2], sda_ff);
    end
  end

  assign scl_rise = !scl_ff && filt_next(scl_sync_ff[1], scl_sync_ff[2], scl_ff);
  assign scl_fall = scl_ff && !filt_next(scl_sync_ff[1], scl_sync_ff[2], scl_ff);
  assign sda_fell = sda_ff && !filt_next(sda_sync_ff[1], sda_sync_ff[2], sda_ff);
  assign sda_rose = !sda_ff && filt_next(sda_sync_ff[1], sda_sync_ff[2], sda_ff);

  // Start and stop each need their own stable window with SCL high.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_arm_ff <= 1'b0;
      stop_arm_ff  <= 1'b0;
      start_cnt_ff <= '0;
      stop_cnt_ff  <= '0;
    end else begin
      if (sda_fell && scl_ff) begin
        start_arm_ff <= 1'b1;
        start_cnt_ff <= '0;
      end else if (!scl_ff || sda_ff || start_det) begin
        start_arm_ff <= 1'b0;
      end else if (start_arm_ff) begin
        start_cnt_ff <= start_cnt_ff + 1'b1;
      end
      if (sda_rose && scl_ff) begin
        stop_arm_ff <= 1'b1;
        stop_cnt_ff <= '0;
      end else if (!scl_ff || sda_ff == 1'b0 || stop_det) begin
        stop_arm_ff <= 1'b0;
      end else if (stop_arm_ff) begin
        stop_cnt_ff <= stop_cnt_ff + 1'b1;
      end
    end
  end

  assign start_det = start_arm_ff && (start_cnt_ff == 4'(hsi2c_pkg::FILTER_CYC - 1));
  assign stop_det  = stop_arm_ff && (stop_cnt_ff == 4'(hsi2c_pkg::FILTER_CYC - 1));

  //////////////////////////////////////////////////////////////////////////////
  // Configuration shadow, frozen while a transfer is in progress, except that sys_reset_seen clears srst_en_ff at any time.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_lsb_ff      <= '0;
      hs_en_ff         <= 1'b0;
      devid_en_ff      <= 1'b0;
      srst_en_ff       <= 1'b0;
      srst_cfg_prev_ff <= 1'b0;
    end else begin
      // A rise of the enable during a frame is kept until the frame ends.
      if (!busy) begin
        srst_cfg_prev_ff <= soft_reset_enable;
      end
      if (sys_reset_seen) begin
        srst_en_ff <= 1'b0;
      end else if (!busy && soft_reset_enable && !srst_cfg_prev_ff) begin
        srst_en_ff <= 1'b1;
      end else if (!busy && !soft_reset_enable) begin
        srst_en_ff <= 1'b0;
      end
      if (!busy) begin
        addr_lsb_ff <= cfg_addr_lsb;
        hs_en_ff    <= high_speed_enable;
        devid_en_ff <= device_id_enable;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Acknowledge decisions on the byte that completes at this SCL rise.
  assign byte_in    = {shift_ff, sda_ff};
  assign sel_i2c    = (host_if_select == hsi2c_pkg::SEL_I2C);
  // Ten-bit headers carry a different prefix and fall out here.
  assign addr_match = (byte_in[7:1] == {ADDR_PREFIX, addr_lsb_ff});
  assign write_ok   = rx_buf_avail && fifo_in_ready && (native_mode || !rx_frame_ovf);
  assign byte_done  = scl_rise && (bitcnt_ff == hsi2c_pkg::BIT_LAST);

  always_comb begin
    nxt_ack = 1'b0;
    if (state_ff == hsi2c_pkg::ST_ADDR) begin
      if (byte_in[7:3] == hsi2c_pkg::HS_CODE_PREFIX) begin
        nxt_ack = 1'b0;
      end else if (byte_in[7:1] == hsi2c_pkg::GEN_CALL_ADDR && !byte_in[0]) begin
        nxt_ack = sel_i2c && srst_en_ff && !hs_active_ff;
      end else if (byte_in[7:1] == hsi2c_pkg::DEVID_ADDR) begin
        nxt_ack = sel_i2c && devid_en_ff && !hs_active_ff
                  && (!byte_in[0] || devid_armed_ff);
      end else if (addr_match && (!hs_active_ff || hs_en_ff)) begin
        nxt_ack = sel_i2c && (byte_in[0] ? tx_frame_avail : write_ok);
      end
    end else if (gc_pend_ff) begin
      nxt_ack = (byte_in == hsi2c_pkg::SOFT_RESET_CMD);
    end else if (devid_pend_ff) begin
      nxt_ack = addr_match && devid_en_ff;
    end else begin
      nxt_ack = write_ok;
    end
  end

  assign fifo_push = byte_done && (state_ff == hsi2c_pkg::ST_WDATA) && !gc_pend_ff
                     && !devid_pend_ff && write_ok;
  assign load_tx   = scl_fall && ((state_ff == hsi2c_pkg::ST_ACK && ack_drv_ff && ack_ok_ff && read_ff)
                     || (state_ff == hsi2c_pkg::ST_RACK && mack_ff));
  assign take_tx   = load_tx && tx_valid;

  //////////////////////////////////////////////////////////////////////////////
  // Byte engine: sample on SCL rise, change SDA on SCL fall.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= hsi2c_pkg::ST_IDLE;
      shift_ff    <= '0;
      tx_shift_ff <= hsi2c_pkg::IDLE_BYTE;
      bitcnt_ff   <= '0;
      sda_drv_ff  <= 1'b0;
      ack_ok_ff   <= 1'b0;
      ack_drv_ff  <= 1'b0;
      read_ff     <= 1'b0;
      mack_ff     <= 1'b0;
    end else if (stop_det) begin
      state_ff   <= hsi2c_pkg::ST_IDLE;
      sda_drv_ff <= 1'b0;
    end else if (start_det) begin
      state_ff   <= hsi2c_pkg::ST_ADDR;
      bitcnt_ff  <= '0;
      sda_drv_ff <= 1'b0;
      ack_drv_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        hsi2c_pkg::ST_IDLE, hsi2c_pkg::ST_SKIP: begin
          sda_drv_ff <= 1'b0;
        end
        hsi2c_pkg::ST_ADDR, hsi2c_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_ff  <= byte_in[6:0];
            bitcnt_ff <= bitcnt_ff + 1'b1;
          end
          if (byte_done) begin
            state_ff  <= hsi2c_pkg::ST_ACK;
            ack_ok_ff <= nxt_ack;
            if (state_ff == hsi2c_pkg::ST_ADDR) begin
              read_ff <= byte_in[0];
            end
          end
        end
        hsi2c_pkg::ST_ACK: begin
          if (scl_fall && !ack_drv_ff) begin
            ack_drv_ff <= 1'b1;
            sda_drv_ff <= ack_ok_ff;
          end else if (scl_fall) begin
            ack_drv_ff <= 1'b0;
            bitcnt_ff  <= '0;
            if (!ack_ok_ff) begin
              sda_drv_ff <= 1'b0;
              state_ff   <= hsi2c_pkg::ST_SKIP;
            end else if (read_ff) begin
              tx_shift_ff <= tx_valid ? tx_data : hsi2c_pkg::IDLE_BYTE;
              sda_drv_ff  <= tx_valid ? !tx_data[7] : 1'b0;
              state_ff    <= hsi2c_pkg::ST_RDATA;
            end else begin
              sda_drv_ff <= 1'b0;
              state_ff   <= hsi2c_pkg::ST_WDATA;
            end
          end
        end
        hsi2c_pkg::ST_RDATA: begin
          if (scl_fall && bitcnt_ff == hsi2c_pkg::BIT_LAST) begin
            sda_drv_ff <= 1'b0;
            state_ff   <= hsi2c_pkg::ST_RACK;
          end else if (scl_fall) begin
            bitcnt_ff   <= bitcnt_ff + 1'b1;
            tx_shift_ff <= {tx_shift_ff[6:0], 1'b1};
            sda_drv_ff  <= !tx_shift_ff[6];
          end
        end
        hsi2c_pkg::ST_RACK: begin
          if (scl_rise) begin
            mack_ff <= !sda_ff;
          end
          if (scl_fall && mack_ff) begin
            bitcnt_ff   <= '0;
            tx_shift_ff <= tx_valid ? tx_data : hsi2c_pkg::IDLE_BYTE;
            sda_drv_ff  <= tx_valid ? !tx_data[7] : 1'b0;
            state_ff    <= hsi2c_pkg::ST_RDATA;
          end else if (scl_fall) begin
            state_ff <= hsi2c_pkg::ST_SKIP;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequence flags: high-speed entry, general call and device-id steps.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_active_ff   <= 1'b0;
      gc_pend_ff     <= 1'b0;
      devid_pend_ff  <= 1'b0;
      devid_armed_ff <= 1'b0;
    end else if (stop_det) begin
      hs_active_ff   <= 1'b0;
      gc_pend_ff     <= 1'b0;
      devid_pend_ff  <= 1'b0;
      devid_armed_ff <= 1'b0;
    end else if (byte_done && state_ff == hsi2c_pkg::ST_ADDR) begin
      if (byte_in[7:3] == hsi2c_pkg::HS_CODE_PREFIX && !hs_active_ff) begin
        hs_active_ff <= 1'b1;
      end
      gc_pend_ff    <= nxt_ack && byte_in[7:1] == hsi2c_pkg::GEN_CALL_ADDR;
      devid_pend_ff <= nxt_ack && byte_in[7:1] == hsi2c_pkg::DEVID_ADDR && !byte_in[0];
      if (byte_in[7:1] == hsi2c_pkg::DEVID_ADDR && byte_in[0]) begin
        devid_armed_ff <= 1'b0;
      end
    end else if (byte_done && state_ff == hsi2c_pkg::ST_WDATA) begin
      gc_pend_ff <= 1'b0;
      if (devid_pend_ff) begin
        devid_armed_ff <= nxt_ack;
        devid_pend_ff  <= 1'b0;
      end
    end
  end

  // Device-id reads flag the first three data requests of the read.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      devid_act_ff <= 1'b0;
      devid_cnt_ff <= '0;
    end else if (stop_det || start_det) begin
      devid_act_ff <= 1'b0;
    end else if (byte_done && state_ff == hsi2c_pkg::ST_ADDR) begin
      devid_act_ff <= nxt_ack && byte_in[7:1] == hsi2c_pkg::DEVID_ADDR && byte_in[0];
      devid_cnt_ff <= '0;
    end else if (take_tx && devid_act_ff) begin
      devid_cnt_ff <= devid_cnt_ff + 1'b1;
      if (devid_cnt_ff == hsi2c_pkg::DEVID_BYTES - 2'h1) begin
        devid_act_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame end, discard and soft reset toward the rest of the chip.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wframe_ff   <= 1'b0;
      eof_ff      <= 1'b0;
      discard_ff  <= 1'b0;
      srst_out_ff <= 1'b0;
    end else begin
      eof_ff     <= 1'b0;
      discard_ff <= 1'b0;
      if (fifo_push) begin
        wframe_ff <= 1'b1;
      end else if (stop_det || start_det) begin
        wframe_ff <= 1'b0;
        eof_ff    <= wframe_ff;
      end else if (byte_done && state_ff == hsi2c_pkg::ST_WDATA && !nxt_ack && !gc_pend_ff && !devid_pend_ff) begin
        wframe_ff  <= 1'b0;
        discard_ff <= 1'b1;
      end
      if (sys_reset_seen || stop_det) begin
        srst_out_ff <= 1'b0;
      end else if (byte_done && state_ff == hsi2c_pkg::ST_WDATA && gc_pend_ff && nxt_ack) begin
        srst_out_ff <= 1'b1;
      end
    end
  end

  hsi2c_fifo #(
    .W     (hsi2c_pkg::DATA_W),
    .DEPTH (hsi2c_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_data   (byte_in),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // SCL is only ever an input, so the host never waits on this slave.
  assign sda_o          = 1'b0;
  assign sda_oe         = sda_drv_ff;
  assign busy           = (state_ff != hsi2c_pkg::ST_IDLE);
  assign hs_pad_mode    = hs_en_ff;
  assign soft_reset_out = srst_out_ff;
  assign rx_eof         = eof_ff;
  assign rx_discard     = discard_ff;
  assign tx_req         = take_tx;
  assign device_id_req  = take_tx && devid_act_ff;
endmodule

// ### dv/hsi2c_host_model.sv
// Behavioural I2C host master that drives the slave link pins.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module hsi2c_host_model (
  input  wire logic core_clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  localparam int HALF = 8;
  logic          sda_drv = 1'b1;

  // The wire is open drain with a pull-up, so it is low while either party pulls it.
  assign sda = sda_drv & ~sda_oe;
  initial scl = 1'b1;

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // SCL moves only inside frames and never waits for the slave.
  task automatic bit_xfer(input logic b, output logic s);
    wt(3);
    sda_drv <= b;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    s = sda;
    scl <= 1'b0;
  endtask

  task automatic start_cond;
    wt(3);
    sda_drv <= 1'b1;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda_drv <= 1'b0;
    wt(HALF);
    scl <= 1'b0;
  endtask

  task automatic stop_cond;
    wt(3);
    sda_drv <= 1'b0;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda_drv <= 1'b1;
    wt(HALF);
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask

  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(~ack, s);
  endtask
endmodule

// ### dv/hsi2c_slave_sva.sv
// Concurrent checks on the ports of the host-side I2C slave link.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module hsi2c_slave_sva (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [2:0] host_if_select,
  input wire logic       high_speed_enable,
  input wire logic       sys_reset_seen,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       busy,
  input wire logic       hs_pad_mode,
  input wire logic       soft_reset_out,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       rx_eof,
  input wire logic       tx_valid,
  input wire logic       tx_req,
  input wire logic       device_id_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_idle_no_drive: assert property (!busy |-> !sda_oe) else $error("SDA pulled outside a frame");
  a_only_pull_low: assert property (sda_o == 1'b0) else $error("SDA driven high");
  a_drive_needs_sel: assert property (sda_oe |-> host_if_select == hsi2c_pkg::SEL_I2C)
    else $error("SDA pulled while link not selected");
  a_cfg_frozen_busy: assert property (busy [*3] |-> $stable(hs_pad_mode))
    else $error("Pad mode changed while busy");
  a_hs_pad_follow: assert property ((!busy && $stable(high_speed_enable)) [*3] |->
    hs_pad_mode == high_speed_enable) else $error("Pad mode not following enable");
  a_srst_in_frame: assert property ($rose(soft_reset_out) |-> busy)
    else $error("Soft reset raised outside a frame");
  a_srst_drop_cause: assert property ($fell(soft_reset_out) |-> !busy || $past(sys_reset_seen))
    else $error("Soft reset dropped without cause");
  a_srst_sys_clear: assert property (sys_reset_seen |=> !soft_reset_out)
    else $error("Soft reset held after system reset");
  a_devid_with_req: assert property (device_id_req |-> tx_req)
    else $error("Device id flag without data request");
  a_req_needs_valid: assert property (tx_req |-> tx_valid && busy && !scl_i)
    else $error("Data request outside a read load");
  a_rx_head_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("Receive head lost before taken");
  a_start_busy: assert property (!busy && scl_i && $fell(sda_i) |-> ##[1:8] busy)
    else $error("Start not detected");
  a_stop_idle: assert property (busy && scl_i && $rose(sda_i) |-> ##[1:8] !busy)
    else $error("Stop not detected");

  c_eof: cover property (rx_eof);
  c_soft_reset: cover property ($rose(soft_reset_out));
  c_devid: cover property (device_id_req && tx_req);
endmodule

bind hsi2c_slave hsi2c_slave_sva u_hsi2c_slave_sva (
  .core_clk, .rst_n, .host_if_select, .high_speed_enable, .sys_reset_seen, .scl_i, .sda_i, .sda_o,
  .sda_oe, .busy, .hs_pad_mode, .soft_reset_out, .rx_data, .rx_valid, .rx_ready, .rx_eof, .tx_valid,
  .tx_req, .device_id_req
);

// ### dv/tb_hsi2c_slave.sv
// Self-checking bench for the host-side I2C slave link.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module tb_hsi2c_slave;
  // Hardwired upper address bits; the value is arbitrary.
  localparam logic [4:0] ADDR_PREFIX = 5'h16;
  localparam logic [7:0] WA = {ADDR_PREFIX, 2'h1, 1'b0};
  localparam logic [7:0] RA = {ADDR_PREFIX, 2'h1, 1'b1};
  localparam logic [7:0] DW = {hsi2c_pkg::DEVID_ADDR, 1'b0};
  localparam logic [7:0] DR = {hsi2c_pkg::DEVID_ADDR, 1'b1};
  localparam logic [7:0] GC = {hsi2c_pkg::GEN_CALL_ADDR, 1'b0};
  localparam logic [7:0] MC = 8'h08;
  localparam logic [2:0] SEL [4] = '{hsi2c_pkg::SEL_NONE, hsi2c_pkg::SEL_UART,
                                     hsi2c_pkg::SEL_SPI_USB, hsi2c_pkg::SEL_I2C};
  logic       core_clk, scl, sda, sda_o, sda_oe, busy, hs_pad_mode, soft_reset_out;
  logic       rx_valid, rx_eof, rx_discard, tx_req, device_id_req;
  logic       rst_n = 1'b0, high_speed_enable = 1'b0, soft_reset_enable = 1'b0, device_id_enable = 1'b0;
  logic       sys_reset_seen = 1'b0, native_mode = 1'b0, rx_buf_avail = 1'b1, rx_frame_ovf = 1'b0;
  logic       rx_ready = 1'b0, tx_frame_avail = 1'b0, tx_valid = 1'b0;
  logic [2:0] host_if_select = hsi2c_pkg::SEL_I2C;
  logic [1:0] cfg_addr_lsb = 2'h1;
  logic [7:0] tx_data = 8'ha5;
  logic [7:0] rx_data;
  int         failures, checked, n_eof, n_disc, n_req, n_id;

  hsi2c_slave u_hsi2c_slave (
    .core_clk, .rst_n, .host_if_select, .cfg_addr_lsb, .high_speed_enable, .soft_reset_enable,
    .device_id_enable, .sys_reset_seen, .native_mode, .rx_buf_avail, .rx_frame_ovf, .scl_i(scl),
    .sda_i(sda), .sda_o, .sda_oe, .busy, .hs_pad_mode, .soft_reset_out, .rx_data, .rx_valid,
    .rx_ready, .rx_eof, .rx_discard, .tx_frame_avail, .tx_data, .tx_valid, .tx_req, .device_id_req
  );
  hsi2c_host_model u_hsi2c_host_model (.core_clk, .sda_oe, .scl, .sda);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    n_eof <= n_eof + int'(rx_eof);
    n_disc <= n_disc + int'(rx_discard);
    n_req <= n_req + int'(tx_req);
    n_id <= n_id + int'(device_id_req);
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] b, input logic ack_exp);
    logic a;
    u_hsi2c_host_model.write_byte(b, a);
    chk({7'h0, a}, {7'h0, ack_exp});
  endtask

  task automatic adr(input logic [7:0] b, input logic ack_exp);
    u_hsi2c_host_model.start_cond();
    wr(b, ack_exp);
  endtask

  task automatic rd(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    u_hsi2c_host_model.read_byte(ack, d);
    chk(d, exp);
  endtask

  task automatic stp;
    u_hsi2c_host_model.stop_cond();
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    cyc(60000);
    failures++;
    test_done();
  end

  initial begin
    cyc(8);
    rst_n <= 1'b1;
    cyc(4);
    chk({3'h0, busy, sda_oe, soft_reset_out, rx_valid, hs_pad_mode}, 8'h00);
    foreach (SEL[i]) begin
      host_if_select <= SEL[i];
      adr(WA, SEL[i] == hsi2c_pkg::SEL_I2C);
      stp();
    end
    adr({ADDR_PREFIX, 2'h2, 1'b0}, 1'b0);
    adr({hsi2c_pkg::TEN_BIT_PREFIX, 4'h2}, 1'b0);
    stp();
    $display("addressing test finished");
    adr(WA, 1'b1);
    for (int i = 0; i < hsi2c_pkg::FIFO_DEPTH; i++) wr(8'h30 + 8'(i), 1'b1);
    stp();
    chk(8'(n_eof), 8'h01);
    adr(WA, 1'b0);
    stp();
    for (int i = 0; i < hsi2c_pkg::FIFO_DEPTH; i++) begin
      chk({7'h0, rx_valid}, 8'h01);
      chk(rx_data, 8'h30 + 8'(i));
      rx_ready <= 1'b1;
      cyc(1);
      rx_ready <= 1'b0;
      cyc(1);
    end
    chk({7'h0, rx_valid}, 8'h00);
    rx_ready <= 1'b1;
    adr(WA, 1'b1);
    wr(8'h5a, 1'b1);
    rx_buf_avail <= 1'b0;
    wr(8'h5b, 1'b0);
    stp();
    chk(8'(n_disc), 8'h01);
    rx_buf_avail <= 1'b1;
    rx_frame_ovf <= 1'b1;
    adr(WA, 1'b0);
    native_mode <= 1'b1;
    adr(WA, 1'b1);
    wr(8'h5c, 1'b1);
    stp();
    rx_frame_ovf <= 1'b0;
    native_mode <= 1'b0;
    adr(WA, 1'b1);
    cfg_addr_lsb <= 2'h2;
    adr(WA, 1'b1);
    stp();
    adr({ADDR_PREFIX, 2'h2, 1'b0}, 1'b1);
    stp();
    cfg_addr_lsb <= 2'h1;
    $display("write test finished");
    adr(RA, 1'b0);
    rd(1'b0, hsi2c_pkg::IDLE_BYTE);
    stp();
    tx_frame_avail <= 1'b1;
    tx_valid <= 1'b1;
    adr(RA, 1'b1);
    rd(1'b1, 8'ha5);
    tx_valid <= 1'b0;
    rd(1'b0, hsi2c_pkg::IDLE_BYTE);
    tx_valid <= 1'b1;
    rd(1'b0, hsi2c_pkg::IDLE_BYTE);
    stp();
    chk(8'(n_req), 8'h01);
    $display("read test finished");
    soft_reset_enable <= 1'b1;
    adr(GC, 1'b1);
    wr(hsi2c_pkg::SOFT_RESET_CMD, 1'b1);
    cyc(6);
    chk({7'h0, soft_reset_out}, 8'h01);
    stp();
    chk({7'h0, soft_reset_out}, 8'h00);
    adr(GC, 1'b1);
    wr(8'h04, 1'b0);
    stp();
    device_id_enable <= 1'b1;
    adr(DW, 1'b1);
    wr(WA, 1'b1);
    adr(DR, 1'b1);
    for (int i = 0; i < 3; i++) rd(i < 2, 8'ha5);
    stp();
    chk(8'(n_id), 8'h03);
    high_speed_enable <= 1'b1;
    cyc(4);
    chk({7'h0, hs_pad_mode}, 8'h01);
    adr(MC, 1'b0);
    adr(WA, 1'b1);
    adr(GC, 1'b0);
    adr(DW, 1'b0);
    stp();
    high_speed_enable <= 1'b0;
    adr(MC, 1'b0);
    adr(WA, 1'b0);
    stp();
    adr(GC, 1'b1);
    wr(hsi2c_pkg::SOFT_RESET_CMD, 1'b1);
    sys_reset_seen <= 1'b1;
    cyc(1);
    sys_reset_seen <= 1'b0;
    cyc(2);
    chk({7'h0, soft_reset_out}, 8'h00);
    stp();
    adr(GC, 1'b0);
    stp();
    device_id_enable <= 1'b0;
    adr(DW, 1'b0);
    wr(WA, 1'b0);
    stp();
    $display("special modes test finished");
    test_done();
  end
endmodule
